// ==== hw/drive_misc_config_status_bank.sv ====
// Purpose: Miscellaneous configuration and status parameter bank of a DC drive controller
// Assumes: All inputs synchronous to sys_clk; mainsTick pulses once per mains cycle
// Notes:   Read and write answers come one cycle after the request
`timescale 1ns/1ps

// Operation
// - Ten menu entries name displayed parameters
// - Node address 0..99, 100 taken as 99
// - Rate bit: 0 gives 4800, 1 gives 9600
// - New rate applies only after drive reset
// - Mode 1 ANSI, 2 send, 3 take, 4 wide
// - Wide mode sends transmit word, stores received
// - Wide value sent as five unsigned ASCII digits
// - Wide transfers at three times mains frequency
// - Mode change applies only after drive reset
// - Firmware versions read as decimal integers
// - Code zero gives free access
// - Code 149 also free; others unlock when written to zero
// - Boot display selects power-on parameter 0..1999
// - Source parameter names sent or taken value
// - Mode 3 scales incoming data before writing
// - Status word packs eight drive flags
// - LED override shows status word on LEDs
// - Mains low stops firing, blanks display
// - After 40 ms healthy, reset then restart
// - Restart follows dip within about 340 ms
module drive_misc_config_status_bank #(
	parameter int          SLOW_DIV        = drive_misc_pkg::SLOW_BAUD_DIV,
	parameter int          FAST_DIV        = drive_misc_pkg::FAST_BAUD_DIV,
	parameter int          SETTLE_CYCLES   = drive_misc_pkg::SETTLE_CYC,
	parameter int          RESTART_CYCLES  = drive_misc_pkg::RESTART_CYC,
	parameter logic [9:0]  MAIN_FW_VERSION = 10'h064,  // Arbitrary value
	parameter logic [9:0]  AUX_FW_VERSION  = 10'h000   // Arbitrary value
) (
	input  wire logic                         sys_clk,
	input  wire logic                         sys_rst,
	input  wire drive_misc_pkg::paramReq_t    paramReq,
	output      drive_misc_pkg::paramRsp_t    paramRsp,
	input  wire logic                         driveReset,
	input  wire drive_misc_pkg::statusFlags_t statusFlags,
	input  wire logic [7:0]                   normalLeds,
	output      logic [7:0]                   ledOut,
	input  wire logic                         mainsTick,
	input  wire logic [15:0]                  wideTxParam,
	input  wire logic [15:0]                  selectedParamValue,
	input  wire logic                         rxValid,
	input  wire logic [15:0]                  rxWord,
	output      logic                         baudTick,
	output      logic                         txValid,
	output      logic [15:0]                  txWord,
	output      logic [39:0]                  txAscii,
	output      logic                         destValid,
	output      logic [15:0]                  destValue,
	output      logic [15:0]                  wideRxParam,
	output      logic [6:0]                   serialAddress,
	output      logic [2:0]                   portMode,
	output      logic [10:0]                  serialSource,
	output      logic [9:0][10:0]             userMenuMap,
	output      logic [10:0]                  bootDisplayParam,
	output      logic                         hvBoardSelect,
	input  wire logic                         mainsLow,
	input  wire logic                         runCmd,
	input  wire logic                         enableCmd,
	output      logic                         firingInhibit,
	output      logic                         displayBlank,
	output      logic                         selfReset,
	output      logic                         restartPulse,
	output      logic                         saveRequest,
	output      logic                         accessUnlocked
);

	// Refuse settings the counters cannot hold
	if (SLOW_DIV < 2 || SLOW_DIV > 65535 || FAST_DIV < 2 || FAST_DIV > 65535) begin : g_bad_div
		$error("Baud divisor out of range");
	end
	if (SETTLE_CYCLES < 1 || RESTART_CYCLES < 1 || SETTLE_CYCLES > 134217727 || RESTART_CYCLES > 134217727) begin : g_bad_ride
		$error("Ride-through count out of range");
	end

	drive_misc_pkg::bankState_t q;
	drive_misc_pkg::bankState_t next_q;

	// Binary to five ASCII digits, most significant character in the top byte
	function automatic logic [39:0] toAscii(input logic [15:0] v);
		logic [15:0] r;
		logic [39:0] a;
		r = v;
		a = '0;
		for (int i = 0; i < 5; i++) begin
			a[i*8 +: 8] = drive_misc_pkg::ASCII_ZERO + 8'(r % 16'd10);
			r = r / 16'd10;
		end
		return a;
	endfunction

	logic        codeOpen;
	logic        dipNow;
	logic        anyReset;
	logic        xferTick;
	logic [15:0] baudLimit;
	logic [23:0] xferLimit;
	logic [26:0] scaledProd;
	logic [17:0] scaledQuot;
	logic [15:0] rdMux;
	logic        wrOk;

	// Access, dip and reset terms
	assign codeOpen  = (q.secCode == drive_misc_pkg::CODE_OPEN)
			|| (q.secCode == drive_misc_pkg::CODE_DELIVERED);
	assign dipNow    = q.rideEnable && mainsLow;
	assign anyReset  = driveReset || q.selfReset;
	assign baudLimit = q.activeRate ? 16'(FAST_DIV - 1) : 16'(SLOW_DIV - 1);
	assign xferLimit = q.mainsPeriod / 24'(drive_misc_pkg::XFER_PER_MAINS);
	assign xferTick  = (q.mainsPeriod != '0) && (q.xferCnt + 24'h000001 >= xferLimit);
	assign scaledProd = 27'(rxWord) * 27'(q.scaling);
	assign scaledQuot = 18'(scaledProd / 27'(drive_misc_pkg::SCALE_UNITY));

	// Read data selection
	always_comb begin
		rdMux = '0;
		case (paramReq.sel)
			drive_misc_pkg::IDX_ACCESS:   rdMux = q.zeroParam;
			drive_misc_pkg::IDX_ADDR:     rdMux = 16'(q.nodeAddr);
			drive_misc_pkg::IDX_RATE:     rdMux = 16'(q.rateSel);
			drive_misc_pkg::IDX_MODE:     rdMux = 16'(q.modeSel);
			drive_misc_pkg::IDX_FW_MAIN:  rdMux = 16'(MAIN_FW_VERSION);
			drive_misc_pkg::IDX_FW_AUX:   rdMux = 16'(AUX_FW_VERSION);
			drive_misc_pkg::IDX_SECURITY: rdMux = 16'(q.secCode);
			drive_misc_pkg::IDX_BOOT:     rdMux = 16'(q.bootSel);
			drive_misc_pkg::IDX_SOURCE:   rdMux = 16'(q.varSource);
			drive_misc_pkg::IDX_SCALING:  rdMux = 16'(q.scaling);
			drive_misc_pkg::IDX_STATUS:   rdMux = 16'(q.statusWord);
			drive_misc_pkg::IDX_LED:      rdMux = 16'(q.ledOverride);
			drive_misc_pkg::IDX_HV_BOARD: rdMux = 16'(q.hvBoard);
			drive_misc_pkg::IDX_RIDE:     rdMux = 16'(q.rideEnable);
			default: begin
				if (paramReq.sel >= drive_misc_pkg::IDX_MENU_LO && paramReq.sel <= drive_misc_pkg::IDX_MENU_HI) begin
					rdMux = 16'(q.menuMap[4'(paramReq.sel - drive_misc_pkg::IDX_MENU_LO)]);
				end
			end
		endcase
	end

	// Next-state logic for the whole bank
	always_comb begin
		next_q = q;
		next_q.rsp       = '0;
		next_q.baudTick  = 1'b0;
		next_q.txValid   = 1'b0;
		next_q.destValid = 1'b0;
		next_q.selfReset = 1'b0;
		next_q.restart   = 1'b0;
		next_q.save      = 1'b0;
		wrOk = 1'b0;

		// Status word follows the drive flags unless software owns it
		if (!q.ledOverride) begin
			next_q.statusWord = statusFlags;
		end

		// Parameter writes, refused while locked except the access parameter
		if (paramReq.wr) begin
			wrOk = codeOpen || q.unlocked || (paramReq.sel == drive_misc_pkg::IDX_ACCESS);
			case (paramReq.sel)
				drive_misc_pkg::IDX_ACCESS: begin
					next_q.zeroParam = paramReq.wdata;
					if (paramReq.wdata == 16'(q.secCode)) begin
						next_q.unlocked = 1'b1;
					end
				end
				drive_misc_pkg::IDX_ADDR:
					if (wrOk) begin
						next_q.nodeAddr = (paramReq.wdata > drive_misc_pkg::ADDR_MAX)
								? 7'(drive_misc_pkg::ADDR_MAX) : 7'(paramReq.wdata);
					end
				drive_misc_pkg::IDX_RATE:     if (wrOk) next_q.rateSel = paramReq.wdata[0];
				drive_misc_pkg::IDX_MODE: begin
					wrOk = wrOk && paramReq.wdata >= 16'(drive_misc_pkg::MODE_ANSI)
							&& paramReq.wdata <= 16'(drive_misc_pkg::MODE_WIDE);
					if (wrOk) next_q.modeSel = 3'(paramReq.wdata);
				end
				drive_misc_pkg::IDX_RSVD:     wrOk = wrOk;
				drive_misc_pkg::IDX_FW_MAIN:  wrOk = 1'b0;
				drive_misc_pkg::IDX_FW_AUX:   wrOk = 1'b0;
				drive_misc_pkg::IDX_SECURITY: begin
					wrOk = wrOk && paramReq.wdata[15:8] == 8'h00;
					if (wrOk) next_q.secCode = paramReq.wdata[7:0];
				end
				drive_misc_pkg::IDX_STATUS:   if (wrOk) next_q.statusWord = paramReq.wdata[7:0];
				drive_misc_pkg::IDX_LED:      if (wrOk) next_q.ledOverride = paramReq.wdata[0];
				drive_misc_pkg::IDX_HV_BOARD: if (wrOk) next_q.hvBoard = paramReq.wdata[0];
				drive_misc_pkg::IDX_RIDE:     if (wrOk) next_q.rideEnable = paramReq.wdata[0];
				default: begin
					// Entries that hold a parameter number 0..1999
					wrOk = wrOk && paramReq.wdata <= drive_misc_pkg::PARAM_NUM_MAX
							&& paramReq.sel <= drive_misc_pkg::IDX_SCALING;
					if (wrOk && paramReq.sel == drive_misc_pkg::IDX_BOOT) next_q.bootSel = 11'(paramReq.wdata);
					if (wrOk && paramReq.sel == drive_misc_pkg::IDX_SOURCE) next_q.varSource = 11'(paramReq.wdata);
					if (wrOk && paramReq.sel == drive_misc_pkg::IDX_SCALING) next_q.scaling = 11'(paramReq.wdata);
					for (int i = 0; i < 10; i++) begin
						if (wrOk && paramReq.sel == drive_misc_pkg::IDX_MENU_LO + 5'(i)) begin
							next_q.menuMap[i] = 11'(paramReq.wdata);
						end
					end
				end
			endcase
			next_q.rsp.ack     = 1'b1;
			next_q.rsp.refused = !wrOk;
		end else if (paramReq.rd) begin
			next_q.rsp.ack   = 1'b1;
			next_q.rsp.rdata = rdMux;
		end

		// Drive reset applies rate and mode, commits a pending save and relocks
		if (anyReset) begin
			next_q.activeRate = q.rateSel;
			next_q.activeMode = q.modeSel;
			next_q.zeroParam  = '0;
			next_q.unlocked   = 1'b0;
			next_q.save       = (q.zeroParam == drive_misc_pkg::SAVE_COMMAND);
		end

		// Bit clock for the serial port at the active rate
		if (q.baudCnt >= baudLimit) begin
			next_q.baudCnt  = '0;
			next_q.baudTick = 1'b1;
		end else begin
			next_q.baudCnt = q.baudCnt + 16'h0001;
		end

		// Mains period measurement and transfer pacing at three per cycle
		if (mainsTick) begin
			next_q.mainsCnt    = '0;
			next_q.mainsPeriod = q.mainsCnt + 24'h000001;
		end else if (q.mainsCnt != 24'hffffff) begin
			next_q.mainsCnt = q.mainsCnt + 24'h000001;
		end
		next_q.xferCnt = xferTick ? '0 : q.xferCnt + 24'h000001;

		// Outgoing words per mode
		if (xferTick && q.activeMode == drive_misc_pkg::MODE_WIDE) begin
			next_q.txValid = 1'b1;
			next_q.txWord  = wideTxParam;
			next_q.txAscii = toAscii(wideTxParam);
		end else if (xferTick && q.activeMode == drive_misc_pkg::MODE_SEND) begin
			next_q.txValid = 1'b1;
			next_q.txWord  = selectedParamValue;
			next_q.txAscii = toAscii(selectedParamValue);
		end

		// Incoming words per mode
		if (rxValid && q.activeMode == drive_misc_pkg::MODE_WIDE) begin
			next_q.wideRx = rxWord;
		end else if (rxValid && q.activeMode == drive_misc_pkg::MODE_TAKE) begin
			next_q.destValid = 1'b1;
			next_q.destValue = (scaledQuot > 18'h0ffff) ? 16'hffff : 16'(scaledQuot);
		end

		// Mains dip ride-through sequence
		case (q.ride)
			drive_misc_pkg::RIDE_NORMAL:
				if (dipNow) next_q.ride = drive_misc_pkg::RIDE_DIP;
			drive_misc_pkg::RIDE_DIP:
				if (!mainsLow) begin
					next_q.ride    = drive_misc_pkg::RIDE_SETTLE;
					next_q.rideCnt = '0;
				end
			drive_misc_pkg::RIDE_SETTLE:
				if (mainsLow) begin
					next_q.ride = drive_misc_pkg::RIDE_DIP;
				end else if (q.rideCnt >= 27'(SETTLE_CYCLES - 1)) begin
					next_q.ride      = drive_misc_pkg::RIDE_RESTART;
					next_q.rideCnt   = '0;
					next_q.selfReset = 1'b1;
				end else begin
					next_q.rideCnt = q.rideCnt + 27'h0000001;
				end
			drive_misc_pkg::RIDE_RESTART:
				if (mainsLow) begin
					next_q.ride = drive_misc_pkg::RIDE_DIP;
				end else if (q.rideCnt >= 27'(RESTART_CYCLES - 1)) begin
					next_q.ride    = drive_misc_pkg::RIDE_NORMAL;
					next_q.restart = runCmd && enableCmd;
				end else begin
					next_q.rideCnt = q.rideCnt + 27'h0000001;
				end
			default: next_q.ride = drive_misc_pkg::RIDE_NORMAL;
		endcase
	end

	// State register with documented reset values
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q            <= '0;
			q.nodeAddr   <= drive_misc_pkg::ADDR_RESET;
			q.modeSel    <= drive_misc_pkg::MODE_RESET;
			q.activeMode <= drive_misc_pkg::MODE_RESET;
			q.secCode    <= drive_misc_pkg::CODE_DELIVERED;
			q.scaling    <= drive_misc_pkg::SCALING_RESET;
			q.ride       <= drive_misc_pkg::RIDE_NORMAL;
		end else begin
			q <= next_q;
		end
	end

	// Outputs
	assign paramRsp         = q.rsp;
	assign ledOut           = q.ledOverride ? q.statusWord : normalLeds;
	assign baudTick         = q.baudTick;
	assign txValid          = q.txValid;
	assign txWord           = q.txWord;
	assign txAscii          = q.txAscii;
	assign destValid        = q.destValid;
	assign destValue        = q.destValue;
	assign wideRxParam      = q.wideRx;
	assign serialAddress    = q.nodeAddr;
	assign portMode         = q.activeMode;
	assign serialSource     = q.varSource;
	assign userMenuMap      = q.menuMap;
	assign bootDisplayParam = q.bootSel;
	assign hvBoardSelect    = q.hvBoard;
	assign firingInhibit    = dipNow || (q.ride != drive_misc_pkg::RIDE_NORMAL);
	assign displayBlank     = dipNow || (q.ride == drive_misc_pkg::RIDE_DIP);
	assign selfReset        = q.selfReset;
	assign restartPulse     = q.restart;
	assign saveRequest      = q.save;
	assign accessUnlocked   = codeOpen || q.unlocked;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	logic [15:0] baudGap;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || baudTick) begin
			baudGap <= sys_rst ? 16'hffff : 16'h0000;  // Count starts at the reset edge, one cycle earlier than after a tick; first period is as long as later ones
		end else begin
			baudGap <= baudGap + 16'h0001;
		end
	end

	a_addr_clamp: assert property (
		paramReq.wr && paramReq.sel == drive_misc_pkg::IDX_ADDR && accessUnlocked
		&& paramReq.wdata > drive_misc_pkg::ADDR_MAX |=> serialAddress == 7'h63)
		else $error("Node address not clamped to 99");
	a_baud_period: assert property (
		baudTick && $past(baudTick, 2) == 1'b0 && $stable(q.activeRate) && baudGap != 16'h0000
		|-> baudGap == 16'(q.activeRate ? FAST_DIV - 1 : SLOW_DIV - 1))
		else $error("Bit clock period wrong");
	a_rate_held: assert property (
		!(driveReset || selfReset) |=> q.activeRate == $past(q.activeRate))
		else $error("Line rate changed without reset");
	a_mode_held: assert property (
		!(driveReset || selfReset) |=> portMode == $past(portMode))
		else $error("Serial mode changed without reset");
	a_wide_store: assert property (
		rxValid && portMode == drive_misc_pkg::MODE_WIDE |=> wideRxParam == $past(rxWord))
		else $error("Received wide word not stored");
	a_wide_send: assert property (
		txValid && portMode == drive_misc_pkg::MODE_WIDE && $stable(portMode) |-> txAscii == toAscii(txWord))
		else $error("Wide word not sent as ASCII digits");
	a_free_access: assert property (
		q.secCode == 8'h00 |-> accessUnlocked)
		else $error("Code zero did not open access");
	a_code_unlock: assert property (
		paramReq.wr && paramReq.sel == drive_misc_pkg::IDX_ACCESS && paramReq.wdata == 16'(q.secCode)
		&& !driveReset && !selfReset |=> accessUnlocked)
		else $error("Matching code did not unlock");
	a_save_seq: assert property (
		q.zeroParam == 16'h0001 && driveReset |=> saveRequest ##1 !saveRequest)
		else $error("Save not requested on reset");
	a_fire_off: assert property (
		q.rideEnable && mainsLow |-> firingInhibit && displayBlank)
		else $error("Firing not stopped on mains dip");
	a_restart_gate: assert property (
		restartPulse |-> $past(runCmd) && $past(enableCmd) && firingInhibit == 1'b0 || mainsLow)
		else $error("Restart without run and enable");
	a_led_override: assert property (
		q.ledOverride |-> ledOut == q.statusWord)
		else $error("LEDs do not show status word");
	a_status_fresh: assert property (
		!q.ledOverride && !(paramReq.wr && paramReq.sel == drive_misc_pkg::IDX_STATUS)
		|=> q.statusWord == $past(statusFlags))
		else $error("Status word not refreshed");

	c_dip_restart: cover property (selfReset ##[1:1000] restartPulse);
	c_wide_tx:     cover property (txValid && portMode == drive_misc_pkg::MODE_WIDE);
	c_take_scaled: cover property (destValid);
	c_save:        cover property (saveRequest);

endmodule // drive_misc_config_status_bank

// ==== hw/drive_misc_pkg.sv ====
// Purpose: Shared constants and types for the miscellaneous configuration and status bank
// Assumes: 200 MHz system clock, parameter numbers of the bank decoded to a 5-bit index
// Notes:   Index 0 is the access/command parameter; indices 1 to 24 are the bank entries
package drive_misc_pkg;

	// Clock and timing
	localparam int CLK_HZ           = 200_000_000;
	localparam int SLOW_BAUD        = 4800;
	localparam int FAST_BAUD        = 9600;
	localparam int SLOW_BAUD_DIV    = CLK_HZ / SLOW_BAUD;
	localparam int FAST_BAUD_DIV    = CLK_HZ / FAST_BAUD;
	localparam int SETTLE_MS        = 40;
	localparam int RECOVER_MS       = 340;
	localparam int SETTLE_CYC       = SETTLE_MS * (CLK_HZ / 1000);
	localparam int RESTART_CYC      = (RECOVER_MS - SETTLE_MS) * (CLK_HZ / 1000);
	localparam int XFER_PER_MAINS   = 3;

	// Parameter indices within the bank
	localparam logic [4:0] IDX_ACCESS    = 5'h00;
	localparam logic [4:0] IDX_MENU_LO   = 5'h01;
	localparam logic [4:0] IDX_MENU_HI   = 5'h0a;
	localparam logic [4:0] IDX_ADDR      = 5'h0b;
	localparam logic [4:0] IDX_RATE      = 5'h0c;
	localparam logic [4:0] IDX_MODE      = 5'h0d;
	localparam logic [4:0] IDX_RSVD      = 5'h0e;
	localparam logic [4:0] IDX_FW_MAIN   = 5'h0f;
	localparam logic [4:0] IDX_FW_AUX    = 5'h10;
	localparam logic [4:0] IDX_SECURITY  = 5'h11;
	localparam logic [4:0] IDX_BOOT      = 5'h12;
	localparam logic [4:0] IDX_SOURCE    = 5'h13;
	localparam logic [4:0] IDX_SCALING   = 5'h14;
	localparam logic [4:0] IDX_STATUS    = 5'h15;
	localparam logic [4:0] IDX_LED       = 5'h16;
	localparam logic [4:0] IDX_HV_BOARD  = 5'h17;
	localparam logic [4:0] IDX_RIDE      = 5'h18;

	// Value limits and reset values
	localparam logic [15:0] ADDR_MAX       = 16'h0063;
	localparam logic [15:0] PARAM_NUM_MAX  = 16'h07cf;
	localparam logic [15:0] SAVE_COMMAND   = 16'h0001;
	localparam logic [6:0]  ADDR_RESET     = 7'h01;
	localparam logic [2:0]  MODE_RESET     = 3'h1;
	localparam logic [7:0]  CODE_OPEN      = 8'h00;
	localparam logic [7:0]  CODE_DELIVERED = 8'h95;
	localparam logic [10:0] SCALING_RESET  = 11'h3e8;
	localparam logic [15:0] SCALE_UNITY    = 16'h03e8;
	localparam logic [7:0]  ASCII_ZERO     = 8'h30;

	// Serial port modes
	localparam logic [2:0] MODE_ANSI  = 3'h1;
	localparam logic [2:0] MODE_SEND  = 3'h2;
	localparam logic [2:0] MODE_TAKE  = 3'h3;
	localparam logic [2:0] MODE_WIDE  = 3'h4;

	// Ride-through states
	typedef enum logic [3:0] {
		RIDE_NORMAL  = 4'b0001,
		RIDE_DIP     = 4'b0010,
		RIDE_SETTLE  = 4'b0100,
		RIDE_RESTART = 4'b1000
	} rideState_t;

	// Status flags, bit 7 down to bit 0
	typedef struct packed {
		logic alarm;
		logic zeroSpeed;
		logic runForward;
		logic runReverse;
		logic bridgeOne;
		logic bridgeTwo;
		logic atSpeed;
		logic currentLimit;
	} statusFlags_t;

	// Parameter access request and answer
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  sel;
		logic [15:0] wdata;
	} paramReq_t;

	typedef struct packed {
		logic        ack;
		logic        refused;
		logic [15:0] rdata;
	} paramRsp_t;

	// Whole state of the bank
	typedef struct packed {
		logic [9:0][10:0] menuMap;
		logic [6:0]       nodeAddr;
		logic             rateSel;
		logic             activeRate;
		logic [2:0]       modeSel;
		logic [2:0]       activeMode;
		logic [7:0]       secCode;
		logic             unlocked;
		logic [15:0]      zeroParam;
		logic [10:0]      bootSel;
		logic [10:0]      varSource;
		logic [10:0]      scaling;
		logic [7:0]       statusWord;
		logic             ledOverride;
		logic             hvBoard;
		logic             rideEnable;
		rideState_t       ride;
		logic [26:0]      rideCnt;
		logic [15:0]      baudCnt;
		logic             baudTick;
		logic [23:0]      mainsCnt;
		logic [23:0]      mainsPeriod;
		logic [23:0]      xferCnt;
		paramRsp_t        rsp;
		logic             txValid;
		logic [15:0]      txWord;
		logic [39:0]      txAscii;
		logic             destValid;
		logic [15:0]      destValue;
		logic [15:0]      wideRx;
		logic             selfReset;
		logic             restart;
		logic             save;
	} bankState_t;

endpackage

// ==== test/serial_partner.sv ====
// Purpose: Far-side drive model that sends one serial word on request
// Assumes: send is a one-cycle pulse from the bench
// Notes:   Idle word is inverted each cycle so stale data never looks valid
`timescale 1ns/1ps
module serial_partner (
	input  wire logic        sys_clk,
	input  wire logic        send,
	input  wire logic [15:0] word,
	output      logic        rxValid,
	output      logic [15:0] rxWord
);
	// Word presented for one cycle, changing pattern otherwise
	always @(posedge sys_clk) begin
		rxValid <= send;
		rxWord  <= send ? word : ($isunknown(rxWord) ? 16'hffff : ~rxWord);
	end
endmodule // serial_partner

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the configuration and status bank
// Assumes: Shortened settle, restart and baud counts
// Notes:   Register answers are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module tb;
	logic                         sys_clk = 1'b0;
	logic                         sys_rst = 1'b1;
	drive_misc_pkg::paramReq_t    req = '0;
	drive_misc_pkg::paramRsp_t    rsp;
	drive_misc_pkg::statusFlags_t flags = '0;
	logic                         driveReset = 1'b0, mainsTick = 1'b0, mainsLow = 1'b0, send = 1'b0;
	logic                         txValid, rxValid, inhibit, blank, selfReset, restartPulse, saveRequest;
	logic                         destValid, unlockOut, hvBoard, runCmd = 1'b1, enableCmd = 1'b1;
	logic [7:0]                   normalLeds = 8'h00, ledOut;
	logic [15:0]                  rxWord, wideRx, txWord, destValue, wideTx = 16'd12345;
	logic [15:0]                  selParam = 16'h0000, partWord = 16'h5a3c;
	logic [6:0]                   addrOut;
	logic [10:0]                  bootOut;
	logic [9:0][10:0]             menuOut;
	logic [39:0]                  txAscii;
	logic [2:0]                   portMode;
	logic [31:0]                  seed = 32'h7fe0;
	logic [16:0]                  expQ[$];
	int                           miscompares = 0, check_count = 0, n;

	drive_misc_config_status_bank #(.SLOW_DIV(8), .FAST_DIV(4), .SETTLE_CYCLES(20), .RESTART_CYCLES(30),
		.MAIN_FW_VERSION(10'h19a)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .paramReq(req), .paramRsp(rsp),
		.driveReset(driveReset), .statusFlags(flags), .normalLeds(normalLeds), .ledOut(ledOut),
		.mainsTick(mainsTick), .wideTxParam(wideTx), .selectedParamValue(selParam), .rxValid(rxValid),
		.rxWord(rxWord), .baudTick(), .txValid(txValid), .txWord(txWord), .txAscii(txAscii),
		.destValid(destValid), .destValue(destValue), .wideRxParam(wideRx), .serialAddress(addrOut),
		.portMode(portMode), .serialSource(), .userMenuMap(menuOut), .bootDisplayParam(bootOut),
		.hvBoardSelect(hvBoard), .mainsLow(mainsLow), .runCmd(runCmd), .enableCmd(enableCmd),
		.firingInhibit(inhibit), .displayBlank(blank), .selfReset(selfReset),
		.restartPulse(restartPulse), .saveRequest(saveRequest), .accessUnlocked(unlockOut));
	serial_partner partner_u (.sys_clk(sys_clk), .send(send), .word(partWord), .rxValid(rxValid), .rxWord(rxWord));

	// Clock at 200 MHz
	always #2.5 sys_clk = ~sys_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic compare(input string what, input logic [39:0] exp, input logic [39:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic access(input logic w, input logic [4:0] s, input logic [15:0] d, input logic [16:0] ex);
		@(posedge sys_clk);
		req <= '{wr: w, rd: !w, sel: s, wdata: d};
		expQ.push_back(ex);
		@(posedge sys_clk);
		req <= '0;
	endtask

	task automatic pulseReset();
		@(posedge sys_clk) driveReset <= 1'b1;
		@(posedge sys_clk) driveReset <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("Counts: %0d compared, %0d mismatched", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Answer monitor takes the oldest queued note
	always @(negedge sys_clk) begin
		if (rsp.ack === 1'b1)
			compare("paramRsp", 40'({rsp.refused, rsp.rdata}), 40'(expQ.pop_front()));
	end

	// Watchdog
	initial begin
		#20000;
		miscompares++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		access(0, 5'h0b, 16'h0, 17'h00001);
		access(0, 5'h11, 16'h0, 17'h00095);
		access(0, 5'h14, 16'h0, 17'h003e8);
		access(1, 5'h0b, 16'd100, 17'h0);
		access(0, 5'h0b, 16'h0, 17'h00063);
		@(negedge sys_clk) compare("serialAddress", 40'(addrOut), 40'h63);
		access(1, 5'h0f, 16'h1, 17'h10000);
		access(0, 5'h0f, 16'h0, 17'h0019a);
		access(1, 5'h12, 16'd1999, 17'h0);
		access(1, 5'h12, 16'd2000, 17'h10000);
		access(1, 5'h01, 16'd303, 17'h0);
		access(1, 5'h17, 16'h1, 17'h0);
		@(negedge sys_clk) compare("bootDisplayParam", 40'(bootOut), 40'd1999);
		compare("userMenuMap", 40'(menuOut[0]), 40'd303);
		compare("hvBoardSelect", 40'(hvBoard), 40'h1);
		$display("Test registers done");
		for (int m = 0; m < 6; m++)
			access(1, 5'h0d, 16'(m), (m == 0 || m == 5) ? 17'h10000 : 17'h0);
		@(negedge sys_clk) compare("portMode", 40'(portMode), 40'h1);
		pulseReset();
		@(negedge sys_clk) compare("portMode", 40'(portMode), 40'h4);
		@(posedge sys_clk) mainsTick <= 1'b1;
		@(posedge sys_clk) mainsTick <= 1'b0;
		repeat (29) @(posedge sys_clk);
		mainsTick <= 1'b1;
		@(posedge sys_clk) mainsTick <= 1'b0;
		n = 0;
		do begin @(negedge sys_clk); n++; end while (txValid !== 1'b1 && n < 60);
		compare("txWord", 40'(txWord), 40'd12345);
		compare("txAscii", txAscii, 40'h3132333435);
		n = 0;
		do begin @(negedge sys_clk); n++; end while (txValid !== 1'b1 && n < 40);
		compare("txGap", 40'(n), 40'd10);
		@(posedge sys_clk) send <= 1'b1;
		@(posedge sys_clk) send <= 1'b0;
		repeat (2) @(negedge sys_clk);
		compare("wideRxParam", 40'(wideRx), 40'h5a3c);
		access(1, 5'h14, 16'd500, 17'h0);
		access(1, 5'h0d, 16'h3, 17'h0);
		pulseReset();
		@(posedge sys_clk) send <= 1'b1;
		@(posedge sys_clk) send <= 1'b0;
		repeat (2) @(negedge sys_clk);
		compare("destValue", 40'({destValid, destValue}), 40'h12d1e);
		seed = lfsr(seed);
		@(posedge sys_clk) selParam <= seed[15:0];
		access(1, 5'h0d, 16'h2, 17'h0);
		pulseReset();
		n = 0;
		do begin @(negedge sys_clk); n++; end while (txValid !== 1'b1 && n < 40);
		compare("txWord", 40'(txWord), 40'(selParam));
		$display("Test serial done");
		seed = lfsr(seed);
		@(posedge sys_clk) flags <= seed[7:0];
		normalLeds <= seed[15:8];
		repeat (3) @(posedge sys_clk);
		access(0, 5'h15, 16'h0, {9'h0, seed[7:0]});
		@(negedge sys_clk) compare("ledOut", 40'(ledOut), 40'(seed[15:8]));
		access(1, 5'h16, 16'h1, 17'h0);
		access(1, 5'h15, 16'h00a5, 17'h0);
		@(negedge sys_clk) compare("ledOut", 40'(ledOut), 40'ha5);
		$display("Test status done");
		access(1, 5'h18, 16'h1, 17'h0);
		@(posedge sys_clk) mainsLow <= 1'b1;
		@(negedge sys_clk) compare("inhibit", 40'({inhibit, blank}), 40'h3);
		@(posedge sys_clk) mainsLow <= 1'b0;
		n = 0;
		while (selfReset !== 1'b1 && n < 60) begin @(negedge sys_clk); n++; end
		compare("settle", 40'(n >= 20 && n < 60), 40'h1);
		n = 0;
		while (restartPulse !== 1'b1 && n < 60) begin @(negedge sys_clk); n++; end
		compare("restart", 40'(n >= 30 && n < 60), 40'h1);
		runCmd <= 1'b0;
		@(posedge sys_clk) mainsLow <= 1'b1;
		@(posedge sys_clk) mainsLow <= 1'b0;
		n = 0;
		do begin @(negedge sys_clk); n++; end while (restartPulse !== 1'b1 && n < 80);
		compare("noRestart", 40'(n), 40'd80);
		$display("Test ride-through done");
		access(1, 5'h11, 16'h0012, 17'h0);
		pulseReset();
		@(negedge sys_clk) compare("accessUnlocked", 40'(unlockOut), 40'h0);
		access(1, 5'h0b, 16'h5, 17'h10000);
		access(1, 5'h00, 16'h0012, 17'h0);
		@(negedge sys_clk) compare("accessUnlocked", 40'(unlockOut), 40'h1);
		access(1, 5'h0b, 16'h5, 17'h0);
		access(1, 5'h00, 16'h0001, 17'h0);
		pulseReset();
		@(negedge sys_clk) compare("saveRequest", 40'(saveRequest), 40'h1);
		$display("Test security done");
		compare("pendingAnswers", 40'(expQ.size()), 40'h0);
		tally_and_finish();
	end
endmodule // tb
